// [rtl/seq_consts.svh]
`ifndef SEQ_CONSTS_SVH
`define SEQ_CONSTS_SVH

`define ADDR_W          8
`define OFS_CTRL        8'h00
`define OFS_QH_LIMIT    8'h04
`define OFS_STATUS      8'h08
`define OFS_IRQ_STAT    8'h0C
`define OFS_IRQ_MASK    8'h10

`define CTRL_W          9
`define CTRL_RST        9'h000
`define QH_LIMIT_W      16
`define QH_LIMIT_RST    16'h03E8
`define IRQ_W           4
`define IRQ_MASK_RST    4'h0

`define IRQ_FPROC_BIT   0
`define IRQ_FLATCH_BIT  1
`define IRQ_ENABLED_BIT 2
`define IRQ_QHALT_BIT   3

`define STAT_CODE_LSB   0
`define STAT_FLAGS_LSB  3
`define STAT_CONT_BIT   11

`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// [rtl/drive_seq_pkg.sv]
package drive_seq_pkg;

    // gray codes along init -> blocked -> allowed -> stack on -> enabled
    typedef enum logic [2:0] {
        ST_INIT    = 3'h0,
        ST_BLOCKED = 3'h1,
        ST_ALLOWED = 3'h3,
        ST_STACKON = 3'h2,
        ST_ENABLED = 3'h6,
        ST_QHALT   = 3'h7,
        ST_FPROC   = 3'h5,
        ST_FLATCH  = 3'h4
    } seq_state_e;

    typedef struct packed {
        logic tripped;
        logic running;
        logic jogging;
        logic stopping;
        logic start_permit;
        logic switched_on;
        logic ready;
        logic health;
    } seq_flags_s;

    typedef struct packed {
        logic qh_mode_coast;
        logic config_mode;
        logic init_done;
        logic trip_reset;
        logic drive_enable;
        logic coast_req;
        logic quick_halt_req;
        logic jog;
        logic run;
    } seq_ctrl_s;

endpackage : drive_seq_pkg

// [rtl/seq_status_decode.sv]
`timescale 1ns/100ps

module seq_status_decode
    import drive_seq_pkg::*;
(
    input  wire seq_state_e state,
    input  wire logic       jog_cmd,
    input  wire logic       stop_cycle,
    output logic [2:0]      code,
    output seq_flags_s      flags
);

    wire in_enabled = (state == ST_ENABLED);
    wire in_fault   = (state == ST_FPROC) || (state == ST_FLATCH);
    wire in_3_to_6  = (state == ST_STACKON) || (state == ST_ENABLED) ||
                      (state == ST_QHALT) || (state == ST_FPROC);

    always_comb begin
        case (state)
            ST_INIT:    code = 3'h0;
            ST_BLOCKED: code = 3'h1;
            ST_ALLOWED: code = 3'h2;
            ST_STACKON: code = 3'h3;
            ST_ENABLED: code = 3'h4;
            ST_QHALT:   code = 3'h5;
            ST_FPROC:   code = 3'h6;
            ST_FLATCH:  code = 3'h7;
            default:    code = 3'h0;
        endcase
    end

    assign flags.tripped      = in_fault;
    assign flags.running      = in_enabled;
    assign flags.jogging      = in_enabled && jog_cmd;
    assign flags.stopping     = (in_enabled && stop_cycle) ||
                                (state == ST_QHALT);
    assign flags.start_permit = in_3_to_6 || (state == ST_ALLOWED);
    assign flags.switched_on  = in_3_to_6;
    assign flags.ready        = in_3_to_6;
    assign flags.health       = !in_fault;

endmodule : seq_status_decode

// [rtl/drive_seq_top.sv]
// Operation
// - report state as code 0 to 7
// - init hold ignores every command but init done and config
// - start blocked refuses switch-on
// - start allowed accepts switch-on
// - stack on holds power stack enabled
// - enabled state drives the motor
// - fault processing handles a trip
// - fault latched waits for trip reset
// - tripped in 6,7; running in 4 only
// - permit 2..6; switched-on, ready 3..6
// - contactor off/on/held by state
// - health high 0..5, low 6,7
// - jogging, stopping only when enabled; stopping in halt
// - trip to fault processing, quench, reset rise
// - blocked/allowed/stack-on moves on run, jog, stops
// - enable, quick halt and halt exit moves
// - init hold until init done, no config
`timescale 1ns/100ps
`include "seq_consts.svh"

module drive_seq_top
    import drive_seq_pkg::*;
(
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    input  wire logic [`ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire logic [`ADDR_W-1:0]   s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    input  wire logic                 trip_in,
    input  wire logic                 stack_quenched_in,
    input  wire logic                 zero_setpoint_in,
    output logic [2:0]                state_code,
    output seq_flags_s                status,
    output logic                      contactor,
    output logic                      irq
);

    // pins from the power stage, two flops before use
    logic [2:0] pin_meta_r;
    logic [2:0] pin_sync_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_meta_r <= 3'h0;
            pin_sync_r <= 3'h0;
        end else begin
            pin_meta_r <= {trip_in, stack_quenched_in, zero_setpoint_in};
            pin_sync_r <= pin_meta_r;
        end
    end
    wire trip_s   = pin_sync_r[2];
    wire quench_s = pin_sync_r[1];
    wire zero_s   = pin_sync_r[0];

    // registers
    seq_ctrl_s              ctrl_r;
    logic [`QH_LIMIT_W-1:0] qh_limit_r;
    logic [`IRQ_W-1:0]      irq_stat_r;
    logic [`IRQ_W-1:0]      irq_mask_r;

    // axi write path: address and data taken in either order
    logic               aw_held_r;
    logic               w_held_r;
    logic [`ADDR_W-1:0] awaddr_r;
    logic [31:0]        wdata_r;
    logic [3:0]         wstrb_r;
    logic               bvalid_r;
    logic [1:0]         bresp_r;

    assign s_axi_awready = !aw_held_r && !bvalid_r;
    assign s_axi_wready  = !w_held_r && !bvalid_r;
    wire aw_take  = s_axi_awvalid && s_axi_awready;
    wire w_take   = s_axi_wvalid && s_axi_wready;
    wire wr_go    = aw_held_r && w_held_r;
    wire [31:0] wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}},
                         {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
    wire [31:0] wbits = wdata_r & wmask;
    wire wr_ctrl  = wr_go && (awaddr_r == `OFS_CTRL);
    wire wr_qhl   = wr_go && (awaddr_r == `OFS_QH_LIMIT);
    wire wr_istat = wr_go && (awaddr_r == `OFS_IRQ_STAT);
    wire wr_imask = wr_go && (awaddr_r == `OFS_IRQ_MASK);
    wire wr_hit   = wr_ctrl || wr_qhl || wr_istat || wr_imask ||
                    (awaddr_r == `OFS_STATUS);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            awaddr_r  <= '0;
            wdata_r   <= 32'h0;
            wstrb_r   <= 4'h0;
            bvalid_r  <= 1'b0;
            bresp_r   <= `RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_held_r <= 1'b1;
                awaddr_r  <= s_axi_awaddr;
            end
            if (w_take) begin
                w_held_r <= 1'b1;
                wdata_r  <= s_axi_wdata;
                wstrb_r  <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_held_r <= 1'b0;
                w_held_r  <= 1'b0;
                bvalid_r  <= 1'b1;
                bresp_r   <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
            end else if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp  = bresp_r;

    // software registers; status is read only, writes to it are dropped
    wire [`CTRL_W-1:0] ctrl_new = (ctrl_r & ~wmask[`CTRL_W-1:0]) |
                                  wbits[`CTRL_W-1:0];
    wire [`QH_LIMIT_W-1:0] qhl_new = (qh_limit_r & ~wmask[`QH_LIMIT_W-1:0]) |
                                     wbits[`QH_LIMIT_W-1:0];
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r     <= `CTRL_RST;
            qh_limit_r <= `QH_LIMIT_RST;
            irq_mask_r <= `IRQ_MASK_RST;
        end else begin
            if (wr_ctrl)
                ctrl_r <= ctrl_new;
            if (wr_qhl)
                qh_limit_r <= qhl_new;
            if (wr_imask)
                irq_mask_r <= wbits[`IRQ_W-1:0];
        end
    end

    // sequencing state machine
    seq_state_e state_r;
    seq_state_e state_nxt;
    logic       runjog_d_r;
    logic       treset_d_r;
    logic [`QH_LIMIT_W-1:0] qh_cnt_r;

    wire runjog     = ctrl_r.run || ctrl_r.jog;
    wire runjog_up  = runjog && !runjog_d_r;
    wire treset_up  = ctrl_r.trip_reset && !treset_d_r;
    wire stop_req   = ctrl_r.coast_req || ctrl_r.quick_halt_req;
    wire stop_cycle = !runjog;
    wire trip_zone  = (state_r == ST_BLOCKED) || (state_r == ST_ALLOWED) ||
                      (state_r == ST_STACKON) || (state_r == ST_ENABLED) ||
                      (state_r == ST_QHALT);
    wire qh_expired = (qh_cnt_r >= qh_limit_r);

    always_comb begin
        state_nxt = state_r;
        if (trip_zone && trip_s) begin
            state_nxt = ST_FPROC;
        end else begin
            case (state_r)
                ST_INIT:
                    if (ctrl_r.init_done && !ctrl_r.config_mode)
                        state_nxt = ST_BLOCKED;
                ST_BLOCKED:
                    if (!runjog && !stop_req)
                        state_nxt = ST_ALLOWED;
                ST_ALLOWED:
                    if (stop_req)
                        state_nxt = ST_BLOCKED;
                    else if (runjog_up)
                        state_nxt = ST_STACKON;
                ST_STACKON:
                    if (stop_req)
                        state_nxt = ST_BLOCKED;
                    else if (!runjog)
                        state_nxt = ST_ALLOWED;
                    else if (ctrl_r.drive_enable)
                        state_nxt = ST_ENABLED;
                ST_ENABLED:
                    if (ctrl_r.coast_req)
                        state_nxt = ST_BLOCKED;
                    else if (ctrl_r.quick_halt_req)
                        state_nxt = ST_QHALT;
                    else if (!ctrl_r.drive_enable)
                        state_nxt = ST_STACKON;
                    else if (!runjog && zero_s)
                        state_nxt = ST_ALLOWED;
                ST_QHALT:
                    if (qh_expired || ctrl_r.qh_mode_coast || zero_s)
                        state_nxt = ST_BLOCKED;
                ST_FPROC:
                    if (quench_s)
                        state_nxt = ST_FLATCH;
                ST_FLATCH:
                    if (!trip_s && treset_up)
                        state_nxt = ST_BLOCKED;
                default:
                    state_nxt = ST_INIT;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r    <= ST_INIT;
            runjog_d_r <= 1'b0;
            treset_d_r <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            runjog_d_r <= runjog;
            treset_d_r <= ctrl_r.trip_reset;
        end
    end

    // halt timer counts only while in quick halt
    always_ff @(posedge aclk) begin
        if (!aresetn || state_r != ST_QHALT)
            qh_cnt_r <= '0;
        else if (!qh_expired)
            qh_cnt_r <= qh_cnt_r + 1'b1;
    end

    // outputs
    logic [2:0] code_nxt;
    seq_flags_s flags_nxt;
    logic       contactor_r;

    seq_status_decode seq_status_decode_inst (
        .state      (state_r),
        .jog_cmd    (ctrl_r.jog),
        .stop_cycle (stop_cycle),
        .code       (code_nxt),
        .flags      (flags_nxt)
    );

    wire cont_on  = (state_r == ST_STACKON) || (state_r == ST_ENABLED) ||
                    (state_r == ST_QHALT) || (state_r == ST_FPROC);
    wire cont_off = (state_r == ST_INIT) || (state_r == ST_FLATCH);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_code  <= 3'h0;
            status      <= '0;
            contactor_r <= 1'b0;
        end else begin
            state_code <= code_nxt;
            status     <= flags_nxt;
            if (cont_on)
                contactor_r <= 1'b1;
            else if (cont_off)
                contactor_r <= 1'b0;
        end
    end
    assign contactor = contactor_r;

    // interrupts: state entry events, set wins over a same-cycle clear
    wire entering = (state_nxt != state_r);
    wire [`IRQ_W-1:0] irq_ev;
    assign irq_ev[`IRQ_FPROC_BIT]   = entering && (state_nxt == ST_FPROC);
    assign irq_ev[`IRQ_FLATCH_BIT]  = entering && (state_nxt == ST_FLATCH);
    assign irq_ev[`IRQ_ENABLED_BIT] = entering && (state_nxt == ST_ENABLED);
    assign irq_ev[`IRQ_QHALT_BIT]   = entering && (state_nxt == ST_QHALT);
    wire [`IRQ_W-1:0] irq_clr = wr_istat ? wbits[`IRQ_W-1:0] : '0;

    always_ff @(posedge aclk) begin
        if (!aresetn)
            irq_stat_r <= '0;
        else
            irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_ev;
    end
    assign irq = |(irq_stat_r & irq_mask_r);

    // axi read path, one cycle after address
    logic        rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0]  rresp_r;
    logic [31:0] rd_mux;
    logic        rd_hit;
    assign s_axi_arready = !rvalid_r;
    wire ar_take = s_axi_arvalid && s_axi_arready;

    always_comb begin
        rd_hit = 1'b1;
        case (s_axi_araddr)
            `OFS_CTRL:     rd_mux = {23'h0, ctrl_r};
            `OFS_QH_LIMIT: rd_mux = {16'h0, qh_limit_r};
            `OFS_STATUS:   rd_mux = {20'h0, contactor_r, status, state_code};
            `OFS_IRQ_STAT: rd_mux = {28'h0, irq_stat_r};
            `OFS_IRQ_MASK: rd_mux = {28'h0, irq_mask_r};
            default: begin
                rd_mux = 32'h0;
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h0;
            rresp_r  <= `RESP_OKAY;
        end else if (ar_take) begin
            rvalid_r <= 1'b1;
            rdata_r  <= rd_mux;
            rresp_r  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata  = rdata_r;
    assign s_axi_rresp  = rresp_r;

    // checks
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    reset_to_init_a: assert property (disable iff (1'b0)
        !aresetn |=> state_r == ST_INIT && state_code == 3'h0)
        else $error("reset did not reach init hold");
    trip_wins_a: assert property (trip_zone && trip_s |=> state_r == ST_FPROC)
        else $error("trip did not win");
    init_hold_a: assert property (
        state_r == ST_INIT && !(ctrl_r.init_done && !ctrl_r.config_mode)
        |=> state_r == ST_INIT)
        else $error("init hold left early");
    blocked_refuse_a: assert property (
        state_r == ST_BLOCKED && !trip_s |=> state_r inside {ST_BLOCKED, ST_ALLOWED})
        else $error("switch-on taken while blocked");
    allowed_accept_a: assert property (
        state_r == ST_ALLOWED && !trip_s && !stop_req && runjog_up
        |=> state_r == ST_STACKON)
        else $error("switch-on refused while allowed");
    latched_hold_a: assert property (
        state_r == ST_FLATCH && !(treset_up && !trip_s) |=> state_r == ST_FLATCH)
        else $error("fault latch released");
    code_track_a: assert property (
        state_r == ST_ENABLED |=> state_code == 3'h4)
        else $error("state code wrong");
    code_fault_a: assert property (
        state_r == ST_FPROC |=> state_code == 3'h6)
        else $error("fault state code wrong");
    // first edge out of reset still shows the reset value, so skip it
    tripped_out_a: assert property (
        $past(aresetn) |-> status.tripped == ($past(state_r) inside {ST_FPROC, ST_FLATCH}))
        else $error("tripped output wrong");
    running_out_a: assert property (
        $past(aresetn) |-> status.running == ($past(state_r) == ST_ENABLED))
        else $error("running output wrong");
    permit_out_a: assert property (
        $past(aresetn) |-> status.ready == status.switched_on &&
        status.switched_on == ($past(state_r) inside {ST_STACKON, ST_ENABLED,
        ST_QHALT, ST_FPROC}) &&
        status.start_permit == (status.switched_on || $past(state_r) == ST_ALLOWED))
        else $error("permit outputs wrong");
    health_out_a: assert property (
        $past(aresetn) |-> status.health == !($past(state_r) inside {ST_FPROC, ST_FLATCH}))
        else $error("health output wrong");
    contactor_hold_a: assert property (
        state_r inside {ST_BLOCKED, ST_ALLOWED} |=> contactor == $past(contactor))
        else $error("contactor changed in hold state");
    contactor_on_a: assert property (cont_on |=> contactor)
        else $error("contactor not driven");
    halt_stopping_a: assert property (
        state_r == ST_QHALT |=> status.stopping && !status.jogging)
        else $error("stopping low in quick halt");
    halt_timeout_a: assert property (
        state_r == ST_QHALT && qh_expired && !trip_s |=> state_r == ST_BLOCKED)
        else $error("quick halt timer ignored");

    reach_enabled_c: cover property (state_r == ST_STACKON ##1 state_r == ST_ENABLED);
    reach_latch_c: cover property (state_r == ST_FPROC ##1 state_r == ST_FLATCH);
    latch_release_c: cover property (state_r == ST_FLATCH ##1 state_r == ST_BLOCKED);
    irq_raise_c: cover property (!irq ##1 irq);

endmodule : drive_seq_top

// [tb/power_stage_model.sv]
`timescale 1ns/100ps

module power_stage_model #(
    parameter int QUENCH_CYC = 20
) (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic [2:0] state_code,
    output logic            stack_quenched
);
    logic [7:0] cnt_r;

    // a real stack takes time to quench, so never answer at once
    always_ff @(posedge aclk) begin
        if (!aresetn || state_code < 3'h6) begin
            cnt_r <= 8'h00;
        end else if (cnt_r != 8'(QUENCH_CYC)) begin
            cnt_r <= cnt_r + 8'h01;
        end
    end

    assign stack_quenched = (cnt_r == 8'(QUENCH_CYC));
endmodule : power_stage_model

// [tb/testbench.sv]
`timescale 1ns/100ps
`include "seq_consts.svh"

module testbench
    import drive_seq_pkg::*;
;
    typedef struct packed {
        logic [8:0]  ctrl;
        logic [1:0]  pin;
        logic [7:0]  wt;
        logic [2:0]  code;
        logic [11:0] st;
    } step_s;

    logic        aclk;
    logic        aresetn;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, rsp;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic        trip, quenched, zero_sp, irq, contactor;
    logic [2:0]  state_code;
    seq_flags_s  status;
    int          mismatches = 0;
    int          checked = 0;
    int          cycles = 0;

    // status word: contactor, eight flags, state code; pin: zero setpoint, trip
    step_s steps [33] = '{
        '{9'h001, 2'h0, 8'h08, 3'h0, 12'h008},
        '{9'h0C0, 2'h0, 8'h08, 3'h0, 12'h008},
        '{9'h041, 2'h0, 8'h08, 3'h1, 12'h009},
        '{9'h040, 2'h0, 8'h08, 3'h2, 12'h04A},
        '{9'h041, 2'h0, 8'h08, 3'h3, 12'h87B},
        '{9'h051, 2'h0, 8'h08, 3'h4, 12'hA7C},
        '{9'h053, 2'h0, 8'h08, 3'h4, 12'hB7C},
        '{9'h043, 2'h0, 8'h08, 3'h3, 12'h87B},
        '{9'h053, 2'h0, 8'h08, 3'h4, 12'hB7C},
        '{9'h057, 2'h0, 8'h08, 3'h5, 12'h8FD},
        '{9'h057, 2'h0, 8'h3C, 3'h1, 12'h809},
        '{9'h040, 2'h0, 8'h08, 3'h2, 12'h84A},
        '{9'h040, 2'h1, 8'h08, 3'h6, 12'hC76},
        '{9'h040, 2'h1, 8'h1E, 3'h7, 12'h407},
        '{9'h064, 2'h1, 8'h08, 3'h7, 12'h407},
        '{9'h044, 2'h0, 8'h08, 3'h7, 12'h407},
        '{9'h064, 2'h0, 8'h08, 3'h1, 12'h009},
        '{9'h040, 2'h0, 8'h08, 3'h2, 12'h04A},
        '{9'h041, 2'h0, 8'h08, 3'h3, 12'h87B},
        '{9'h049, 2'h0, 8'h08, 3'h1, 12'h809},
        '{9'h040, 2'h0, 8'h08, 3'h2, 12'h84A},
        '{9'h041, 2'h0, 8'h08, 3'h3, 12'h87B},
        '{9'h051, 2'h0, 8'h08, 3'h4, 12'hA7C},
        '{9'h050, 2'h0, 8'h08, 3'h4, 12'hAFC},
        '{9'h050, 2'h2, 8'h08, 3'h2, 12'h84A},
        '{9'h051, 2'h2, 8'h08, 3'h4, 12'hA7C},
        '{9'h055, 2'h2, 8'h08, 3'h1, 12'h809},
        '{9'h050, 2'h0, 8'h08, 3'h2, 12'h84A},
        '{9'h051, 2'h0, 8'h08, 3'h4, 12'hA7C},
        '{9'h155, 2'h0, 8'h08, 3'h1, 12'h809},
        '{9'h040, 2'h0, 8'h08, 3'h2, 12'h84A},
        '{9'h051, 2'h0, 8'h08, 3'h4, 12'hA7C},
        '{9'h059, 2'h0, 8'h08, 3'h1, 12'h809}
    };

    drive_seq_top drive_seq_top_inst (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .trip_in(trip),
        .stack_quenched_in(quenched), .zero_setpoint_in(zero_sp),
        .state_code(state_code), .status(status), .contactor(contactor), .irq(irq)
    );

    power_stage_model #(.QUENCH_CYC(20)) power_stage_model_inst (
        .aclk(aclk), .aresetn(aresetn), .state_code(state_code),
        .stack_quenched(quenched)
    );

    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    task automatic stop_test();
        $display("checks %0d, mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : stop_test

    // generous ceiling, the sequence needs well under a thousand cycles
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            mismatches++;
            stop_test();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask : wr

    task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : rdr

    initial begin
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready, trip, zero_sp} = '0;
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'hF;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rdr(`OFS_STATUS, rd, rsp);
        check(rd, 32'h0000_0008);
        rdr(`OFS_QH_LIMIT, rd, rsp);
        check(rd, 32'h0000_03E8);
        rdr(`OFS_IRQ_MASK, rd, rsp);
        check(rd, 32'h0000_0000);
        rdr(8'h14, rd, rsp);
        check({rd[29:0], rsp}, 32'(`RESP_SLVERR));
        wr(8'h14, 32'h0000_00FF, rsp);
        check(32'(rsp), 32'(`RESP_SLVERR));
        $display("test registers done");
        wr(`OFS_QH_LIMIT, 32'h0000_0028, rsp);
        foreach (steps[i]) begin
            {zero_sp, trip} <= steps[i].pin;
            wr(`OFS_CTRL, {23'h0, steps[i].ctrl}, rsp);
            repeat (steps[i].wt) @(posedge aclk);
            check(32'(state_code), 32'(steps[i].code));
            check(32'(status), 32'(steps[i].st[10:3]));
            check(32'(contactor), 32'(steps[i].st[11]));
            rdr(`OFS_STATUS, rd, rsp);
            check(rd, 32'(steps[i].st));
        end
        $display("test sequencer done");
        rdr(`OFS_IRQ_STAT, rd, rsp);
        check(rd, 32'h0000_000F);
        check(32'(irq), 32'h0);
        wr(`OFS_IRQ_MASK, 32'h0000_0002, rsp);
        check(32'(irq), 32'h1);
        wr(`OFS_IRQ_STAT, 32'h0000_000F, rsp);
        check(32'(irq), 32'h0);
        rdr(`OFS_IRQ_STAT, rd, rsp);
        check(rd, 32'h0000_0000);
        $display("test interrupts done");
        stop_test();
    end
endmodule : testbench
